//--- design/uhrrc_core_if.sv
// interface joining the control core with its frame timer and root ports
`default_nettype none
interface uhrrc_core_if;
	import uhrrc_pkg::*;
	logic glob_rst; // whole-logic reset (chip or bus-wide)
	logic hc_rst; // controller soft reset in progress
	logic frame_run; // frame timer counts
	logic frame_clr; // frame timer back to frame start
	logic fidx_wr; // software load of the frame index
	logic [FIDX_W-1:0] fidx_wdata;
	logic [FIDX_W-1:0] frame_index;
	logic port_wr; // write strobe to one port register
	logic port_sel;
	logic [15:0] port_wdata;
	logic [NUM_PORTS-1:0] attached;
	logic [NUM_PORTS-1:0] low_speed;
	logic [15:0] port_stat [NUM_PORTS];
	modport ctl (output glob_rst, hc_rst, frame_run, frame_clr, fidx_wr, fidx_wdata, port_wr, port_sel,
		port_wdata, attached, low_speed, input frame_index, port_stat);
	modport frame (input glob_rst, frame_run, frame_clr, fidx_wr, fidx_wdata, output frame_index);
	modport port (input glob_rst, hc_rst, port_wr, port_sel, port_wdata, attached, low_speed,
		output port_stat);
endinterface
`default_nettype wire

//--- design/uhrrc_frame_timer.sv
// one millisecond frame timer and frame index counter
`default_nettype none
module uhrrc_frame_timer import uhrrc_pkg::*; #(
	parameter int FRAME_LEN = FRAME_CYCLES
) (
	input wire logic sys_clk,
	uhrrc_core_if.frame cif
);
	// ----------------------------------------------------------------
	// counter state
	// ----------------------------------------------------------------
	logic [31:0] cnt_q, cnt_d; // cycles into the current frame
	logic [FIDX_W-1:0] idx_q, idx_d; // frame index

	// next values: clear wins, then a load, then counting
	always_comb begin
		cnt_d = cnt_q;
		idx_d = idx_q;
		if (cif.frame_clr) begin
			cnt_d = '0; // restart at a frame boundary, index kept
		end else if (cif.frame_run) begin
			if (cnt_q == 32'(FRAME_LEN - 1)) begin
				cnt_d = '0;
				idx_d = idx_q + 11'h001;
			end else begin
				cnt_d = cnt_q + 32'h1;
			end
		end
		// frozen when neither run nor clear: debug stop keeps its place
		if (cif.fidx_wr) begin
			idx_d = cif.fidx_wdata;
		end
	end

	// register stage
	always_ff @(posedge sys_clk) begin
		if (cif.glob_rst) begin
			cnt_q <= '0;
			idx_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			idx_q <= idx_d;
		end
	end

	assign cif.frame_index = idx_q;
endmodule
`default_nettype wire

//--- design/uhrrc_pkg.sv
// shared constants for the usb host run/stop and reset control block
`default_nettype none
package uhrrc_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses on the apb bus)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CMD = 8'h00; // command: run, soft reset, bus reset, debug
	localparam logic [7:0] OFF_STS = 8'h04; // status: halted and fatal error flags
	localparam logic [7:0] OFF_FIDX = 8'h08; // frame index
	localparam logic [7:0] OFF_PSC0 = 8'h0c; // port 0 state/control
	localparam logic [7:0] OFF_PSC1 = 8'h10; // port 1 state/control
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CMD_RUN = 0; // run_halt_ctl
	localparam int CMD_HCRST = 1; // controller_soft_reset
	localparam int CMD_GRST = 2; // bus_wide_reset_ctl
	localparam int CMD_DBG = 5; // single_step_debug
	localparam int STS_BERR = 3; // host bus error
	localparam int STS_PERR = 4; // descriptor consistency failure
	localparam int STS_HALT = 5; // halted_flag
	localparam int PSC_CONN = 0; // connect status
	localparam int PSC_CCHG = 1; // connect change
	localparam int PSC_EN = 2; // port enabled
	localparam int PSC_ECHG = 3; // enable change
	localparam int PSC_LS = 8; // low speed device attached
	localparam int NUM_PORTS = 2;
	localparam int FIDX_W = 11;
	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_VAL = 32'h0000_0000;
	localparam int CLK_PERIOD_NS = 25; // 40 mhz system clock
	localparam int FRAME_NS = 1000000; // 1.0 ms frame
	localparam int FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS; // longest time, rounds down
	localparam int DET_NS = 5333; // about 64 full speed bit times
	localparam int DET_CYCLES = DET_NS / CLK_PERIOD_NS;
	localparam int HCRST_CYCLES = 16; // length of the internal soft reset pulse
	// ----------------------------------------------------------------
	// control state machine
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HALT = 2'b00,
		ST_RUN = 2'b01,
		ST_STOP = 2'b10,
		ST_HCRST = 2'b11
	} uhrrc_state_type;
endpackage
`default_nettype wire

//--- design/uhrrc_root_ports.sv
// root hub port connect/disconnect machines, one per port
`default_nettype none
module uhrrc_root_ports import uhrrc_pkg::*; #(
	parameter int DET_LEN = DET_CYCLES
) (
	input wire logic sys_clk,
	uhrrc_core_if.port cif
);
	genvar gi;
	// ----------------------------------------------------------------
	// per port state
	// ----------------------------------------------------------------
	for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
		logic conn_q, conn_d; // connect status
		logic cchg_q, cchg_d; // connect change, write one to clear
		logic en_q, en_d; // port enabled
		logic echg_q, echg_d; // enable change, write one to clear
		logic ls_q, ls_d; // low speed
		logic [15:0] det_q, det_d; // settle delay after soft reset
		logic wr;

		assign wr = cif.port_wr && (cif.port_sel == 1'(gi));

		// next values
		always_comb begin
			conn_d = conn_q;
			cchg_d = cchg_q;
			en_d = en_q;
			echg_d = echg_q;
			ls_d = ls_q;
			det_d = det_q;
			// software side first so hardware events override
			if (wr) begin
				if (cif.port_wdata[PSC_CCHG]) cchg_d = 1'b0;
				if (cif.port_wdata[PSC_ECHG]) echg_d = 1'b0;
				en_d = cif.port_wdata[PSC_EN] && conn_q; // cannot enable an empty port
			end
			if (cif.hc_rst) begin
				// virtual disconnect even with a device present
				conn_d = 1'b0;
				en_d = 1'b0;
				ls_d = 1'b0;
				cchg_d = 1'b1;
				echg_d = 1'b1;
				det_d = 16'(DET_LEN);
			end else if (det_q != 16'h0000) begin
				det_d = det_q - 16'h0001; // detection held off
			end else if (cif.attached[gi] != conn_q) begin
				// fresh detection of connect and speed
				conn_d = cif.attached[gi];
				ls_d = cif.attached[gi] && cif.low_speed[gi];
				cchg_d = 1'b1;
				if (!cif.attached[gi] && en_q) begin
					en_d = 1'b0;
					echg_d = 1'b1;
				end
			end
		end

		// register stage
		always_ff @(posedge sys_clk) begin
			if (cif.glob_rst) begin
				conn_q <= 1'b0;
				cchg_q <= 1'b0;
				en_q <= 1'b0;
				echg_q <= 1'b0;
				ls_q <= 1'b0;
				det_q <= '0;
			end else begin
				conn_q <= conn_d;
				cchg_q <= cchg_d;
				en_q <= en_d;
				echg_q <= echg_d;
				ls_q <= ls_d;
				det_q <= det_d;
			end
		end

		// only bits 8 and 3:0 live here; soft reset touches nothing else
		assign cif.port_stat[gi] = {7'h00, ls_q, 4'h0, echg_q, en_q, cchg_q, conn_q};
	end
endmodule
`default_nettype wire

//--- design/uhrrc_top.sv
// usb host controller run/stop, single step and reset control with apb registers
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`default_nettype none
module uhrrc_top import uhrrc_pkg::*; #(
	parameter int FRAME_LEN = FRAME_CYCLES, // shorten for simulation
	parameter int DET_LEN = DET_CYCLES
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic consistency_err,
	input wire logic host_bus_err,
	input wire logic txn_busy,
	input wire logic td_fetch,
	input wire logic [NUM_PORTS-1:0] dev_attached,
	input wire logic [NUM_PORTS-1:0] dev_low_speed,
	output logic exec_en,
	output logic sof_restart,
	output logic txn_abort,
	output logic [NUM_PORTS-1:0] usb_reset_drive,
	output logic [FIDX_W-1:0] frame_index
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	uhrrc_core_if cif();
	logic int_rst; // whole-logic reset
	logic setup; // apb setup cycle
	logic wr_acc; // apb write takes effect
	logic addr_ok; // address maps to a register
	logic run_q, run_d; // run_halt_ctl
	logic hcrst_q, hcrst_d; // controller_soft_reset
	logic grst_q, grst_d; // bus_wide_reset_ctl
	logic dbg_q, dbg_d; // single_step_debug
	logic perr_q, perr_d; // consistency failure flag
	logic berr_q, berr_d; // host bus error flag
	logic halt_q, halt_d; // halted_flag
	uhrrc_state_type st_q, st_d; // execution state
	logic [4:0] hcnt_q, hcnt_d; // soft reset length count
	logic exec_q, exec_d; // engine allowed to run transactions
	logic sof_q, sof_d; // restart from frame start
	logic abort_q, abort_d; // abort transaction pulse
	logic frun_q, frun_d; // frame timer running
	logic fclr_q, fclr_d; // frame timer cleared
	logic [NUM_PORTS-1:0] ures_q, ures_d; // usb reset signalling
	logic [31:0] rdata_q, rdata_d;
	logic rdy_q, rdy_d;
	logic err_q, err_d;
	logic [31:0] cmd_word;
	logic [31:0] sts_word;

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	uhrrc_frame_timer #(
		.FRAME_LEN(FRAME_LEN)
	) u_frame (
		.sys_clk(sys_clk),
		.cif(cif.frame)
	);

	uhrrc_root_ports #(
		.DET_LEN(DET_LEN)
	) u_ports (
		.sys_clk(sys_clk),
		.cif(cif.port)
	);

	// chip reset or the bus reset bit clears the frame timer, ports, status flags and state machine
	assign int_rst = srst || grst_q;
	assign cif.glob_rst = int_rst;
	assign cif.hc_rst = (st_q == ST_HCRST);
	assign cif.frame_run = frun_q;
	assign cif.frame_clr = fclr_q;
	assign cif.attached = dev_attached;
	assign cif.low_speed = dev_low_speed;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// zero wait states: pready rises in the first access cycle
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && rdy_q && pwrite && !err_q;
	assign addr_ok = (paddr == OFF_CMD) || (paddr == OFF_STS) || (paddr == OFF_FIDX) ||
		(paddr == OFF_PSC0) || (paddr == OFF_PSC1);
	assign cmd_word = {26'h0, dbg_q, 2'b00, grst_q, hcrst_q, run_q};
	assign sts_word = {26'h0, halt_q, perr_q, berr_q, 3'b000};
	// frame index accepted only while stopped
	assign cif.fidx_wr = wr_acc && (paddr == OFF_FIDX) && !run_q;
	assign cif.fidx_wdata = pwdata[FIDX_W-1:0];
	assign cif.port_wr = wr_acc && ((paddr == OFF_PSC0) || (paddr == OFF_PSC1));
	assign cif.port_sel = (paddr == OFF_PSC1);
	assign cif.port_wdata = pwdata[15:0];

	// read data is captured in the setup cycle
	always_comb begin
		rdata_d = rdata_q;
		rdy_d = setup;
		err_d = 1'b0; // the error answer stands only beside its ready
		if (setup) begin
			err_d = !addr_ok; // unmapped: slave error, write dropped
			unique case (paddr)
				OFF_CMD: rdata_d = cmd_word;
				OFF_STS: rdata_d = sts_word;
				OFF_FIDX: rdata_d = {21'h0, cif.frame_index};
				OFF_PSC0: rdata_d = {16'h0, cif.port_stat[0]};
				OFF_PSC1: rdata_d = {16'h0, cif.port_stat[1]};
				default: rdata_d = RST_VAL;
			endcase
		end
	end

	// bus answer registers; follow chip reset only so the bus lives on
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_q <= RST_VAL;
			rdy_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rdy_q <= rdy_d;
			err_q <= err_d;
		end
	end

	// ----------------------------------------------------------------
	// command register
	// ----------------------------------------------------------------
	// hardware clears win over a software write in the same cycle
	always_comb begin
		run_d = run_q;
		hcrst_d = hcrst_q;
		grst_d = grst_q;
		dbg_d = dbg_q;
		if (wr_acc && (paddr == OFF_CMD)) begin
			run_d = pwdata[CMD_RUN];
			hcrst_d = pwdata[CMD_HCRST] || hcrst_q; // software cannot cut it short
			grst_d = pwdata[CMD_GRST]; // only software or chip reset clears it
			// debug is meant to change only while halted; not enforced
			dbg_d = pwdata[CMD_DBG];
		end
		if (consistency_err || host_bus_err) begin
			run_d = 1'b0;
		end
		if (dbg_q && td_fetch && (st_q == ST_RUN)) begin
			run_d = 1'b0; // single step: stop after this descriptor
		end
		if ((st_q == ST_HCRST) && (hcnt_q == 5'h00)) begin
			hcrst_d = 1'b0;
			run_d = 1'b0;
		end
		if (grst_q) begin
			// bus reset holds every other control bit at its reset value
			run_d = 1'b0;
			hcrst_d = 1'b0;
			dbg_d = 1'b0;
		end
	end

	// the bus reset bit itself survives its own reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			run_q <= 1'b0;
			hcrst_q <= 1'b0;
			grst_q <= 1'b0;
			dbg_q <= 1'b0;
		end else begin
			run_q <= run_d;
			hcrst_q <= hcrst_d;
			grst_q <= grst_d;
			dbg_q <= dbg_d;
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// write one to clear; a new error in the same cycle stays set
	always_comb begin
		perr_d = perr_q;
		berr_d = berr_q;
		if (wr_acc && (paddr == OFF_STS)) begin
			if (pwdata[STS_PERR]) perr_d = 1'b0;
			if (pwdata[STS_BERR]) berr_d = 1'b0;
		end
		if (consistency_err) perr_d = 1'b1;
		if (host_bus_err) berr_d = 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (int_rst) begin
			perr_q <= 1'b0;
			berr_q <= 1'b0;
		end else begin
			perr_q <= perr_d;
			berr_q <= berr_d;
		end
	end

	// ----------------------------------------------------------------
	// execution state machine
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		hcnt_d = hcnt_q;
		halt_d = halt_q;
		sof_d = 1'b0;
		abort_d = 1'b0;
		fclr_d = 1'b0;
		unique case (st_q)
			ST_HALT: begin
				if (hcrst_q) begin
					st_d = ST_HCRST;
				end else if (run_q) begin
					st_d = ST_RUN;
					halt_d = 1'b0;
					if (!dbg_q) begin
						// fresh start at a frame boundary from the frame index
						sof_d = 1'b1;
						fclr_d = 1'b1;
					end
					// in debug the engine resumes its saved place
				end
			end
			ST_RUN: begin
				if (hcrst_q) begin
					st_d = ST_HCRST;
				end else if (!run_q) begin
					st_d = ST_STOP;
				end
			end
			ST_STOP: begin
				// the transaction on the wire is allowed to finish
				if (hcrst_q) begin
					st_d = ST_HCRST;
				end else if (!txn_busy) begin
					st_d = ST_HALT;
					halt_d = 1'b1;
					// normal stop rewinds the timer; debug stop freezes it
					fclr_d = !dbg_q;
				end
			end
			ST_HCRST: begin
				if (hcnt_q == 5'h00) begin
					st_d = ST_HALT;
				end else begin
					hcnt_d = hcnt_q - 5'h01;
				end
			end
		endcase
		if (hcrst_q && (st_q != ST_HCRST)) begin
			// entering soft reset: cut off the wire at once
			hcnt_d = 5'(HCRST_CYCLES - 1);
			abort_d = 1'b1;
			fclr_d = 1'b1;
			halt_d = 1'b0;
		end
	end

	// engine permission and frame timer follow the next state
	always_comb begin
		exec_d = (st_d == ST_RUN);
		frun_d = (st_d == ST_RUN) || (st_d == ST_STOP);
		ures_d = {NUM_PORTS{grst_q}};
	end

	always_ff @(posedge sys_clk) begin
		if (int_rst) begin
			st_q <= ST_HALT;
			hcnt_q <= '0;
			halt_q <= 1'b0;
			sof_q <= 1'b0;
			abort_q <= 1'b0;
			fclr_q <= 1'b0;
			exec_q <= 1'b0;
			frun_q <= 1'b0;
		end else begin
			st_q <= st_d;
			hcnt_q <= hcnt_d;
			halt_q <= halt_d;
			sof_q <= sof_d;
			abort_q <= abort_d;
			fclr_q <= fclr_d;
			exec_q <= exec_d;
			frun_q <= frun_d;
		end
	end

	// usb reset follows chip reset only, so it stays up during bus reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ures_q <= '0; // chip reset never signals on the usb
		end else begin
			ures_q <= ures_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = rdata_q;
	assign pready = rdy_q;
	assign pslverr = err_q;
	assign exec_en = exec_q;
	assign sof_restart = sof_q;
	assign txn_abort = abort_q;
	assign usb_reset_drive = ures_q;
	assign frame_index = cif.frame_index;
endmodule
`default_nettype wire

//--- verification/uhrrc_top_sva.sv
// concurrent checks on the ports of the run/stop and reset control top
`default_nettype none
module uhrrc_top_sva import uhrrc_pkg::*; (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic consistency_err,
	input wire logic host_bus_err,
	input wire logic exec_en,
	input wire logic sof_restart,
	input wire logic txn_abort,
	input wire logic [NUM_PORTS-1:0] usb_reset_drive
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	logic cmd_wr; // command write takes effect at this edge
	assign cmd_wr = psel && penable && pready && pwrite && (paddr == OFF_CMD);
	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	apb_ready_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
	slverr_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	// ----------------------------------------------------------------
	// resets
	// ----------------------------------------------------------------
	bus_reset_a: assert property
		(cmd_wr && pwdata[CMD_GRST] |-> ##[1:3] usb_reset_drive == 2'h3) else $error("no usb reset drive");
	// chip reset must stay silent on the wire, so this one is not disabled by it
	chip_reset_a: assert property
		(@(posedge sys_clk) disable iff (1'b0) srst |=> usb_reset_drive == 2'h0) else $error("reset on chip reset");
	soft_abort_a: assert property
		(cmd_wr && pwdata[CMD_HCRST] && !pwdata[CMD_GRST] && usb_reset_drive == 2'h0 |-> ##[1:3] txn_abort)
		else $error("no abort on soft reset");
	abort_pulse_a: assert property (txn_abort |=> !txn_abort) else $error("abort not a pulse");
	// ----------------------------------------------------------------
	// run and stop
	// ----------------------------------------------------------------
	sof_start_a: assert property
		(sof_restart |-> exec_en && !$past(exec_en)) else $error("restart without start");
	fatal_stop_a: assert property
		((consistency_err || host_bus_err) && exec_en |-> ##[1:4] !exec_en) else $error("error did not stop");
	run_stop_a: assert property
		(cmd_wr && !pwdata[CMD_RUN] && exec_en |-> ##[1:3] !exec_en) else $error("stop not taken");
endmodule
`default_nettype wire

//--- verification/uhrrc_top_tb.sv
// self-checking bench for the run/stop and reset control block
`default_nettype none
module uhrrc_top_tb import uhrrc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FL = 50; // shortened frame
	localparam int DL = 8; // shortened detect delay
	localparam int GR_HOLD = 200; // shortened bus reset hold
	logic sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, exec_en, sof_restart, txn_abort;
	logic cerr = 1'b0, berr = 1'b0, txn_busy = 1'b0, td_fetch = 1'b0;
	logic [1:0] plug = 2'h3, slow = 2'h2, att, ls, usb_reset_drive;
	logic [FIDX_W-1:0] frame_index, fi;
	int n_mismatch = 0, total_checks = 0, cycles = 0, n_sof = 0, n_abort = 0, sofs, rst_len;
	uhrrc_top #(.FRAME_LEN(FL), .DET_LEN(DL)) uut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .consistency_err(cerr), .host_bus_err(berr), .txn_busy(txn_busy), .td_fetch(td_fetch),
		.dev_attached(att), .dev_low_speed(ls), .exec_en(exec_en), .sof_restart(sof_restart),
		.txn_abort(txn_abort), .usb_reset_drive(usb_reset_drive), .frame_index(frame_index));
	uhrrc_usb_dev dev (.sys_clk(sys_clk), .usb_reset_drive(usb_reset_drive), .plug(plug), .slow(slow),
		.dev_attached(att), .dev_low_speed(ls), .rst_len(rst_len));
	initial forever #12.5 sys_clk = ~sys_clk;
	// pulse counters and hang guard
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (sof_restart === 1'b1) n_sof <= n_sof + 1;
		if (txn_abort === 1'b1) n_abort <= n_abort + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one apb transfer; the wait ends only on sampled ready, the guard cuts a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd & m, e);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		rdm(OFF_CMD, 32'hffff_ffff, 32'h0);
		rdm(8'h40, 32'hffff_ffff, 32'h0);
		check({31'h0, err}, 32'h1);
		// load the index while stopped, then a normal start
		wr(OFF_FIDX, 32'h0000_0123);
		rdm(OFF_FIDX, 32'h7ff, 32'h123);
		wr(OFF_CMD, 32'h1);
		wait_cyc(4);
		check({31'h0, exec_en}, 32'h1);
		check(32'(n_sof), 32'h1);
		check({21'h0, frame_index}, 32'h123);
		wait_cyc(3 * FL);
		wr(OFF_FIDX, 32'h0); // refused while running
		rdm(OFF_FIDX, 32'hffff_f800, 32'h0);
		check({31'h0, rd[10:0] > 11'h123}, 32'h1);
		// stop with a transaction still on the wire
		txn_busy <= 1'b1;
		wr(OFF_CMD, 32'h0);
		wait_cyc(20);
		rdm(OFF_STS, 32'h20, 32'h0);
		txn_busy <= 1'b0;
		wait_cyc(4);
		rdm(OFF_STS, 32'h20, 32'h20);
		check({31'h0, exec_en}, 32'h0);
		// a normal stop rewinds only the timer: the index itself stays put
		fi = frame_index;
		wait_cyc(FL + 5);
		check({21'h0, frame_index}, {21'h0, fi});
		// both fatal errors stop the schedule
		for (int k = 0; k < 2; k++) begin
			wr(OFF_CMD, 32'h1);
			wait_cyc(4);
			if (k == 0) cerr <= 1'b1;
			else berr <= 1'b1;
			wait_cyc(1);
			cerr <= 1'b0;
			berr <= 1'b0;
			wait_cyc(6);
			rdm(OFF_CMD, 32'h1, 32'h0);
			rdm(OFF_STS, 32'h38, (k == 0) ? 32'h30 : 32'h28);
			wr(OFF_STS, 32'h18);
			rdm(OFF_STS, 32'h18, 32'h0);
		end
		// single step: debug changed only while halted
		wr(OFF_CMD, 32'h20);
		wr(OFF_CMD, 32'h21);
		wait_cyc(2 * FL);
		txn_busy <= 1'b1;
		td_fetch <= 1'b1;
		wait_cyc(1);
		td_fetch <= 1'b0;
		wait_cyc(3);
		rdm(OFF_CMD, 32'h21, 32'h20);
		txn_busy <= 1'b0;
		wait_cyc(4);
		rdm(OFF_STS, 32'h20, 32'h20);
		fi = frame_index;
		wait_cyc(3 * FL);
		check({21'h0, frame_index}, {21'h0, fi});
		sofs = n_sof;
		wr(OFF_CMD, 32'h21);
		wait_cyc(4);
		check({31'h0, exec_en}, 32'h1);
		check(32'(n_sof), 32'(sofs));
		wr(OFF_CMD, 32'h20);
		wait_cyc(6);
		wr(OFF_CMD, 32'h0);
		// soft reset with an enabled low speed port
		wr(OFF_PSC1, 32'h4);
		wr(OFF_CMD, 32'h2);
		// state enters soft reset one edge later, the ports follow one edge after that
		wait_cyc(2);
		rdm(OFF_PSC1, 32'h10f, 32'h00a);
		check(32'(n_abort), 32'h1);
		wait_cyc(20);
		rdm(OFF_CMD, 32'h2, 32'h0);
		wait_cyc(DL + 4);
		rdm(OFF_PSC1, 32'h101, 32'h101);
		rdm(OFF_PSC0, 32'h101, 32'h001);
		// bus reset, held by software, then a silent chip reset
		wr(OFF_FIDX, 32'h0000_0055);
		wr(OFF_CMD, 32'h4);
		wait_cyc(4);
		check({30'h0, usb_reset_drive}, 32'h3);
		rdm(OFF_FIDX, 32'h7ff, 32'h0);
		rdm(OFF_PSC1, 32'h10f, 32'h0);
		wait_cyc(GR_HOLD);
		wr(OFF_CMD, 32'h0);
		wait_cyc(4);
		check({30'h0, usb_reset_drive}, 32'h0);
		check({31'h0, rst_len >= GR_HOLD}, 32'h1);
		srst <= 1'b1;
		wait_cyc(3);
		check({30'h0, usb_reset_drive}, 32'h0);
		srst <= 1'b0;
		rdm(OFF_CMD, 32'hffff_ffff, 32'h0);
		stop_test();
	end
endmodule
bind uhrrc_top uhrrc_top_sva chk (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.consistency_err(consistency_err), .host_bus_err(host_bus_err), .exec_en(exec_en),
	.sof_restart(sof_restart), .txn_abort(txn_abort), .usb_reset_drive(usb_reset_drive));
`default_nettype wire

//--- verification/uhrrc_usb_dev.sv
// behavioural devices plugged into the two root ports
`default_nettype none
module uhrrc_usb_dev import uhrrc_pkg::*; (
	input wire logic sys_clk,
	input wire logic [NUM_PORTS-1:0] usb_reset_drive,
	input wire logic [NUM_PORTS-1:0] plug,
	input wire logic [NUM_PORTS-1:0] slow,
	output logic [NUM_PORTS-1:0] dev_attached,
	output logic [NUM_PORTS-1:0] dev_low_speed,
	output var int rst_len
);
	timeunit 1ns;
	timeprecision 1ps;
	// speed sense only means something while a device is present
	assign dev_attached = plug;
	assign dev_low_speed = plug & slow;
	// count cycles of reset signalling seen on both ports at once
	initial rst_len = 0;
	always @(posedge sys_clk) begin
		if (&usb_reset_drive) begin
			rst_len <= rst_len + 1;
		end
	end
endmodule
`default_nettype wire
